// [rtl/asi_ctrl.sv]
// front-panel status, alarm, cutoff and supply lamp controller
// assumes software alarm states arrive over the register port and that
// supply samples come from a converter on core_clk
module asi_ctrl #(
	parameter int unsigned BLINK_HALF_CYC = asi_pkg::BLINK_HALF_CYC
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic card_hold_reset,
	input wire logic cutoff_button,
	input wire logic [11:0] supply_a_level,
	input wire logic [11:0] supply_b_level,
	output logic fail_lamp,
	output logic role_lamp_green,
	output logic role_lamp_amber,
	output logic severest_alarm_lamp,
	output logic serious_alarm_lamp,
	output logic minor_alarm_lamp,
	output logic far_terminal_alarm_lamp,
	output logic sync_lamp,
	output logic alarm_cutoff_lamp,
	output logic audible_alarm_drive,
	output logic [2:0] supply_a_lamp,
	output logic [2:0] supply_b_lamp
);

	////////////////////////////////////////////////////////////////////
	// registers

	logic [2:0] ctrl_r;
	logic [4:0] sw_alarm_r;
	logic [11:0] thr_xlo_r;
	logic [11:0] thr_lo_r;
	logic [11:0] thr_hi_r;
	logic [11:0] thr_xhi_r;
	logic [4:0] irq_stat_r;
	logic [4:0] irq_mask_r;
	logic [31:0] rdata_r;

	wire wr_ctrl = reg_write && (reg_addr == asi_pkg::REG_CTRL);
	wire wr_alarm = reg_write && (reg_addr == asi_pkg::REG_ALARM);
	wire wr_xlo = reg_write && (reg_addr == asi_pkg::REG_THR_XLO);
	wire wr_lo = reg_write && (reg_addr == asi_pkg::REG_THR_LO);
	wire wr_hi = reg_write && (reg_addr == asi_pkg::REG_THR_HI);
	wire wr_xhi = reg_write && (reg_addr == asi_pkg::REG_THR_XHI);
	wire wr_mask = reg_write && (reg_addr == asi_pkg::REG_MASK);
	wire rd_irq = reg_read && (reg_addr == asi_pkg::REG_IRQ);

	wire booting = ctrl_r[asi_pkg::CTRL_BOOT];
	wire is_active = ctrl_r[asi_pkg::CTRL_ACTIVE];
	wire db_write = ctrl_r[asi_pkg::CTRL_DBWR];

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl_r <= asi_pkg::CTRL_RST;
			sw_alarm_r <= 5'h00;
			thr_xlo_r <= asi_pkg::THR_XLO_RST;
			thr_lo_r <= asi_pkg::THR_LO_RST;
			thr_hi_r <= asi_pkg::THR_HI_RST;
			thr_xhi_r <= asi_pkg::THR_XHI_RST;
			irq_mask_r <= 5'h00;
		end else begin
			if (wr_ctrl) ctrl_r <= reg_wdata[2:0];
			if (wr_alarm) sw_alarm_r <= reg_wdata[4:0];
			if (wr_xlo) thr_xlo_r <= reg_wdata[11:0];
			if (wr_lo) thr_lo_r <= reg_wdata[11:0];
			if (wr_hi) thr_hi_r <= reg_wdata[11:0];
			if (wr_xhi) thr_xhi_r <= reg_wdata[11:0];
			if (wr_mask) irq_mask_r <= reg_wdata[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// pins and blink divider

	logic card_rst_s;
	logic button_s;
	logic button_prev_r;
	logic [22:0] blink_cnt_r;
	logic blink_r;

	asi_sync3 u_sync_rst (
		.core_clk(core_clk),
		.reset(reset),
		.din(card_hold_reset),
		.dout(card_rst_s)
	);

	asi_sync3 u_sync_btn (
		.core_clk(core_clk),
		.reset(reset),
		.din(cutoff_button),
		.dout(button_s)
	);

	wire blink_tick = (blink_cnt_r == 23'(BLINK_HALF_CYC - 1));
	wire press = button_s && !button_prev_r;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			blink_cnt_r <= 23'h00_0000;
			blink_r <= 1'b0;
			button_prev_r <= 1'b0;
		end else begin
			blink_cnt_r <= blink_tick ? 23'h00_0000 : blink_cnt_r + 23'h00_0001;
			if (blink_tick) blink_r <= !blink_r;
			button_prev_r <= button_s;
		end
	end

	////////////////////////////////////////////////////////////////////
	// supply bands

	asi_pkg::asi_band_type band_a;
	asi_pkg::asi_band_type band_b;

	asi_band u_band_a (
		.level(supply_a_level),
		.thr_xlo(thr_xlo_r),
		.thr_lo(thr_lo_r),
		.thr_hi(thr_hi_r),
		.thr_xhi(thr_xhi_r),
		.band(band_a)
	);

	asi_band u_band_b (
		.level(supply_b_level),
		.thr_xlo(thr_xlo_r),
		.thr_lo(thr_lo_r),
		.thr_hi(thr_hi_r),
		.thr_xhi(thr_xhi_r),
		.band(band_b)
	);

	wire thr_ok = (thr_xlo_r < thr_lo_r) && (thr_lo_r < thr_hi_r) &&
		(thr_hi_r < thr_xhi_r);
	wire supply_bad = (band_a != asi_pkg::BAND_GREEN) ||
		(band_b != asi_pkg::BAND_GREEN);
	wire [2:0] lamp_a_nxt = 3'h1 << band_a;
	wire [2:0] lamp_b_nxt = 3'h1 << band_b;

	////////////////////////////////////////////////////////////////////
	// alarm cutoff

	asi_pkg::asi_cut_type cut_r;
	asi_pkg::asi_cut_type cut_nxt;
	logic [4:0] alarm_prev_r;
	logic [4:0] cut_orig_r;

	wire [4:0] alarm_vec = {supply_bad, sw_alarm_r[3:0]};
	wire any_alarm = |alarm_vec;
	wire new_alarm = |(alarm_vec & ~alarm_prev_r);
	wire orig_gone = ~|(cut_orig_r & alarm_vec);
	wire take_cut = press && any_alarm && !new_alarm;

	always_comb begin
		cut_nxt = cut_r;
		case (cut_r)
			asi_pkg::CUT_IDLE: begin
				if (take_cut) cut_nxt = asi_pkg::CUT_ON;
			end
			asi_pkg::CUT_ON: begin
				if (new_alarm) cut_nxt = asi_pkg::CUT_IDLE;
				else if (orig_gone) cut_nxt = asi_pkg::CUT_IDLE;
			end
			default: cut_nxt = asi_pkg::CUT_IDLE;
		endcase
	end

	wire cut_on_nxt = (cut_nxt == asi_pkg::CUT_ON);
	wire audible_nxt = any_alarm && !cut_on_nxt;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cut_r <= asi_pkg::CUT_IDLE;
			alarm_prev_r <= 5'h00;
			cut_orig_r <= 5'h00;
		end else begin
			cut_r <= cut_nxt;
			alarm_prev_r <= alarm_vec;
			if (cut_r == asi_pkg::CUT_IDLE && take_cut) cut_orig_r <= alarm_vec;
		end
	end

	////////////////////////////////////////////////////////////////////
	// lamps

	wire card_blink = booting || db_write;
	wire fail_nxt = card_rst_s ? 1'b1 : (card_blink && blink_r);
	wire role_on = db_write ? blink_r : 1'b1;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fail_lamp <= 1'b1;
			role_lamp_green <= 1'b0;
			role_lamp_amber <= 1'b0;
			severest_alarm_lamp <= 1'b0;
			serious_alarm_lamp <= 1'b0;
			minor_alarm_lamp <= 1'b0;
			far_terminal_alarm_lamp <= 1'b0;
			sync_lamp <= 1'b0;
			alarm_cutoff_lamp <= 1'b0;
			audible_alarm_drive <= 1'b0;
			supply_a_lamp <= 3'h0;
			supply_b_lamp <= 3'h0;
		end else begin
			fail_lamp <= fail_nxt;
			role_lamp_green <= is_active && role_on;
			role_lamp_amber <= !is_active && role_on;
			severest_alarm_lamp <= sw_alarm_r[asi_pkg::ALM_SEVEREST_ALARM_LAMP];
			serious_alarm_lamp <= sw_alarm_r[asi_pkg::ALM_MAJ];
			minor_alarm_lamp <= sw_alarm_r[asi_pkg::ALM_MIN];
			far_terminal_alarm_lamp <= sw_alarm_r[asi_pkg::ALM_REM];
			sync_lamp <= sw_alarm_r[asi_pkg::SW_SYNC];
			alarm_cutoff_lamp <= cut_on_nxt;
			audible_alarm_drive <= audible_nxt;
			supply_a_lamp <= lamp_a_nxt;
			supply_b_lamp <= lamp_b_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupts and read-back

	logic sync_prev_r;
	logic [4:0] irq_set;

	always_comb begin
		irq_set = 5'h00;
		irq_set[asi_pkg::IRQ_NEW_ALM] = new_alarm;
		irq_set[asi_pkg::IRQ_CUT_ON] = (cut_r == asi_pkg::CUT_IDLE) && cut_on_nxt;
		irq_set[asi_pkg::IRQ_CUT_OFF] = (cut_r == asi_pkg::CUT_ON) && !cut_on_nxt;
		irq_set[asi_pkg::IRQ_SUPPLY] = supply_bad && !alarm_prev_r[asi_pkg::ALM_SUPPLY];
		irq_set[asi_pkg::IRQ_SYNC_LOST] = sync_prev_r && !sw_alarm_r[asi_pkg::SW_SYNC];
	end

	wire [31:0] status_word = {23'h00_0000, thr_ok, audible_alarm_drive,
		alarm_cutoff_lamp, supply_b_lamp, supply_a_lamp};

	wire [31:0] rd_mux =
		(reg_addr == asi_pkg::REG_CTRL) ? {29'h0000_0000, ctrl_r} :
		(reg_addr == asi_pkg::REG_ALARM) ? {27'h000_0000, sw_alarm_r} :
		(reg_addr == asi_pkg::REG_THR_XLO) ? {20'h0_0000, thr_xlo_r} :
		(reg_addr == asi_pkg::REG_THR_LO) ? {20'h0_0000, thr_lo_r} :
		(reg_addr == asi_pkg::REG_THR_HI) ? {20'h0_0000, thr_hi_r} :
		(reg_addr == asi_pkg::REG_THR_XHI) ? {20'h0_0000, thr_xhi_r} :
		(reg_addr == asi_pkg::REG_STATUS) ? status_word :
		(reg_addr == asi_pkg::REG_IRQ) ? {27'h000_0000, irq_stat_r} :
		(reg_addr == asi_pkg::REG_MASK) ? {27'h000_0000, irq_mask_r} :
		32'h0000_0000;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_stat_r <= 5'h00;
			sync_prev_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			// a set in the clearing read's cycle survives
			irq_stat_r <= (rd_irq ? 5'h00 : irq_stat_r) | irq_set;
			sync_prev_r <= sw_alarm_r[asi_pkg::SW_SYNC];
			rdata_r <= reg_read ? rd_mux : 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_r;
	assign irq = |(irq_stat_r & irq_mask_r);

	////////////////////////////////////////////////////////////////////
	// checks

	fail_in_reset_a: assert property (
		@(posedge core_clk) disable iff (reset)
		card_rst_s |=> fail_lamp)
		else $error("fail lamp dark while card held in reset");

	fail_dark_idle_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!card_rst_s && !booting && !db_write |=> !fail_lamp)
		else $error("fail lamp lit with no reset, boot or write");

	role_colour_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!$past(reset) && !db_write |=>
			(role_lamp_green == $past(is_active)) &&
			(role_lamp_amber == !$past(is_active)))
		else $error("role lamp colour does not follow role");

	role_blink_a: assert property (
		@(posedge core_clk) disable iff (reset)
		db_write && !blink_r |=> !role_lamp_green && !role_lamp_amber)
		else $error("role lamp steady during database write");

	severity_lamps_a: assert property (
		@(posedge core_clk) disable iff (reset)
		##1 severest_alarm_lamp == $past(sw_alarm_r[asi_pkg::ALM_SEVEREST_ALARM_LAMP]) &&
			minor_alarm_lamp == $past(sw_alarm_r[asi_pkg::ALM_MIN]))
		else $error("severity lamp does not follow alarm");

	far_lamp_a: assert property (
		@(posedge core_clk) disable iff (reset)
		sw_alarm_r[asi_pkg::ALM_REM] |=> far_terminal_alarm_lamp)
		else $error("far terminal lamp dark with remote alarm");

	sync_lamp_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!sw_alarm_r[asi_pkg::SW_SYNC] |=> !sync_lamp)
		else $error("sync lamp lit while unlocked");

	cut_press_a: assert property (
		@(posedge core_clk) disable iff (reset)
		cut_r == asi_pkg::CUT_IDLE && take_cut |=>
			alarm_cutoff_lamp && !audible_alarm_drive)
		else $error("cutoff press not honoured");

	cut_cancel_a: assert property (
		@(posedge core_clk) disable iff (reset)
		cut_r == asi_pkg::CUT_ON && new_alarm |=>
			!alarm_cutoff_lamp && audible_alarm_drive)
		else $error("new alarm did not cancel cutoff");

	cut_clear_a: assert property (
		@(posedge core_clk) disable iff (reset)
		cut_r == asi_pkg::CUT_ON && orig_gone |=> !alarm_cutoff_lamp)
		else $error("cutoff held after originating alarm cleared");

	supply_green_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!$past(reset) && supply_a_level >= thr_lo_r &&
			supply_a_level <= thr_hi_r |=> supply_a_lamp == 3'h1)
		else $error("supply A not green in normal band");

	supply_amber_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!$past(reset) && supply_a_level > thr_hi_r &&
			supply_a_level <= thr_xhi_r |=> supply_a_lamp == 3'h2)
		else $error("supply A not amber in high warning band");

	supply_red_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!$past(reset) && (supply_a_level < thr_xlo_r ||
			supply_a_level > thr_xhi_r) |=> supply_a_lamp == 3'h4)
		else $error("supply A not red outside extreme band");

	supply_b_red_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!$past(reset) && supply_b_level < thr_xlo_r |=>
			supply_b_lamp == 3'h4)
		else $error("supply B not red below extreme low");

	supply_alarm_a: assert property (
		@(posedge core_clk) disable iff (reset)
		!$past(reset) && supply_b_level > thr_hi_r && thr_ok |=>
			audible_alarm_drive || alarm_cutoff_lamp)
		else $error("out of range supply raised no alarm");

	thr_order_a: assert property (
		@(posedge core_clk) disable iff (reset)
		thr_xlo_r >= thr_lo_r |-> !thr_ok)
		else $error("misordered thresholds reported as good");

endmodule

// [rtl/asi_pkg.sv]
// constants, field layouts and types of the front-panel indicator block
// assumes a single 20 MHz core clock and a plain register port
package asi_pkg;

	localparam int unsigned CLK_KHZ = 20_000;
	localparam int unsigned BLINK_HALF_MS = 250;
	localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
	localparam int unsigned BLINK_CNT_W = 23;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned VOLT_W = 12;
	localparam int unsigned ALM_W = 5;
	localparam int unsigned IRQ_W = 5;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ALARM = 8'h04;
	localparam logic [7:0] REG_THR_XLO = 8'h08;
	localparam logic [7:0] REG_THR_LO = 8'h0c;
	localparam logic [7:0] REG_THR_HI = 8'h10;
	localparam logic [7:0] REG_THR_XHI = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_IRQ = 8'h1c;
	localparam logic [7:0] REG_MASK = 8'h20;

	// control fields
	localparam int unsigned CTRL_BOOT = 0;
	localparam int unsigned CTRL_ACTIVE = 1;
	localparam int unsigned CTRL_DBWR = 2;
	localparam logic [2:0] CTRL_RST = 3'h1;

	// alarm vector fields; the supply alarm is the block's own
	localparam int unsigned ALM_SEVEREST_ALARM_LAMP = 0;
	localparam int unsigned ALM_MAJ = 1;
	localparam int unsigned ALM_MIN = 2;
	localparam int unsigned ALM_REM = 3;
	localparam int unsigned ALM_SUPPLY = 4;
	localparam int unsigned SW_SYNC = 4;

	// interrupt status fields
	localparam int unsigned IRQ_NEW_ALM = 0;
	localparam int unsigned IRQ_CUT_ON = 1;
	localparam int unsigned IRQ_CUT_OFF = 2;
	localparam int unsigned IRQ_SUPPLY = 3;
	localparam int unsigned IRQ_SYNC_LOST = 4;

	// status fields
	localparam int unsigned ST_SUPA = 0;
	localparam int unsigned ST_SUPB = 3;
	localparam int unsigned ST_CUT = 6;
	localparam int unsigned ST_AUDIBLE = 7;
	localparam int unsigned ST_THR_OK = 8;

	// three-colour lamp bit positions
	localparam int unsigned LAMP_GREEN = 0;
	localparam int unsigned LAMP_AMBER = 1;
	localparam int unsigned LAMP_RED = 2;

	localparam logic [11:0] THR_XLO_RST = 12'h0400;
	localparam logic [11:0] THR_LO_RST = 12'h0600;
	localparam logic [11:0] THR_HI_RST = 12'h0a00;
	localparam logic [11:0] THR_XHI_RST = 12'h0c00;

	typedef enum logic [1:0] {BAND_GREEN, BAND_AMBER, BAND_RED} asi_band_type;
	typedef enum logic {CUT_IDLE, CUT_ON} asi_cut_type;

endpackage

// [rtl/asi_sync3.sv]
// three-stage synchroniser for an asynchronous pin
// assumes the pin is a slow level; output moves once stages two and three agree
module asi_sync3 (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic din,
	output logic dout
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic dout_r;
	wire agree = (s2_r == s3_r);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			dout_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (agree) begin
				dout_r <= s3_r;
			end
		end
	end

	assign dout = dout_r;

endmodule

// [rtl/asi_band.sv]
// classifies one supply sample into green, amber or red band
// assumes thresholds ordered extreme low < low < high < extreme high
module asi_band (
	input wire logic [11:0] level,
	input wire logic [11:0] thr_xlo,
	input wire logic [11:0] thr_lo,
	input wire logic [11:0] thr_hi,
	input wire logic [11:0] thr_xhi,
	output asi_pkg::asi_band_type band
);

	wire in_green = (level >= thr_lo) && (level <= thr_hi);
	wire in_amber = (level >= thr_xlo) && (level <= thr_xhi);

	assign band = in_green ? asi_pkg::BAND_GREEN :
		in_amber ? asi_pkg::BAND_AMBER : asi_pkg::BAND_RED;

endmodule

// [tb/tb.sv]
// self-checking bench for the front-panel indicator controller
// assumes asi_ctrl with a short blink half period and the register map
// of asi_pkg; all inputs driven by non-blocking assignment at posedge
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int unsigned HALF = 4;

	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic irq;
	logic card_hold_reset = 1'b0;
	logic cutoff_button = 1'b0;
	logic [11:0] supply_a_level = 12'h800;
	logic [11:0] supply_b_level = 12'h800;
	logic fail_lamp, role_lamp_green, role_lamp_amber;
	logic severest_alarm_lamp, serious_alarm_lamp, minor_alarm_lamp;
	logic far_terminal_alarm_lamp, sync_lamp;
	logic alarm_cutoff_lamp, audible_alarm_drive;
	logic [2:0] supply_a_lamp, supply_b_lamp;
	logic [2:0] mon;
	logic [4:0] alm_lamps;
	int miscompares = 0;
	int n_tests = 0;

	assign mon = {fail_lamp, role_lamp_amber, role_lamp_green};
	assign alm_lamps = {sync_lamp, far_terminal_alarm_lamp, minor_alarm_lamp,
		serious_alarm_lamp, severest_alarm_lamp};

	always #25 core_clk = ~core_clk;

	asi_ctrl #(.BLINK_HALF_CYC(HALF)) dut_u (
		.core_clk(core_clk),
		.reset(reset),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.irq(irq),
		.card_hold_reset(card_hold_reset),
		.cutoff_button(cutoff_button),
		.supply_a_level(supply_a_level),
		.supply_b_level(supply_b_level),
		.fail_lamp(fail_lamp),
		.role_lamp_green(role_lamp_green),
		.role_lamp_amber(role_lamp_amber),
		.severest_alarm_lamp(severest_alarm_lamp),
		.serious_alarm_lamp(serious_alarm_lamp),
		.minor_alarm_lamp(minor_alarm_lamp),
		.far_terminal_alarm_lamp(far_terminal_alarm_lamp),
		.sync_lamp(sync_lamp),
		.alarm_cutoff_lamp(alarm_cutoff_lamp),
		.audible_alarm_drive(audible_alarm_drive),
		.supply_a_lamp(supply_a_lamp),
		.supply_b_lamp(supply_b_lamp)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// leaves the bench at a negedge with outputs settled
	task automatic settle(input int n);
		cyc(n);
		@(negedge core_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask

	task automatic toggles(input int sel, output logic [31:0] n);
		logic p;
		n = 0;
		@(negedge core_clk);
		p = mon[sel];
		repeat (5 * HALF) begin
			@(negedge core_clk);
			if (mon[sel] !== p)
				n++;
			p = mon[sel];
		end
	endtask

	task automatic press();
		@(posedge core_clk);
		cutoff_button <= 1'b1;
		cyc(6);
		cutoff_button <= 1'b0;
		settle(6);
	endtask

	////////////////////////////////////////////////////////////////////////
	logic [31:0] d, n;
	logic [7:0] thr_a [4] = '{asi_pkg::REG_THR_XLO, asi_pkg::REG_THR_LO,
		asi_pkg::REG_THR_HI, asi_pkg::REG_THR_XHI};
	logic [11:0] thr_v [4] = '{asi_pkg::THR_XLO_RST, asi_pkg::THR_LO_RST,
		asi_pkg::THR_HI_RST, asi_pkg::THR_XHI_RST};
	logic [11:0] lv [9] = '{12'h800, 12'h600, 12'ha00, 12'h5ff, 12'h400,
		12'ha01, 12'hc00, 12'h3ff, 12'hc01};
	logic [2:0] lx [9] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4,
		3'h4};

	initial begin
		cyc(15);
		@(negedge core_clk);
		check("fail_in_reset", fail_lamp, 1);
		check("supa_in_reset", supply_a_lamp, 0);
		@(posedge core_clk);
		reset <= 1'b0;
		rd(asi_pkg::REG_CTRL, d);
		check("ctrl_rst", d, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			rd(thr_a[i], d);
			check("thr_rst", d, {20'h0_0000, thr_v[i]});
		end
		wr(8'h24, 32'hffff_ffff);
		rd(8'h24, d);
		check("unmapped", d, 0);
		rd(asi_pkg::REG_STATUS, d);
		check("status_rst", d, 32'h0000_0109);
		toggles(2, n);
		check("fail_boot_blink", n >= 4, 1);
		@(posedge core_clk);
		card_hold_reset <= 1'b1;
		settle(8);
		toggles(2, n);
		check("fail_hold_steady", n, 0);
		check("fail_hold_lit", fail_lamp, 1);
		@(posedge core_clk);
		card_hold_reset <= 1'b0;
		wr(asi_pkg::REG_CTRL, 32'h0000_0002);
		settle(8);
		check("role_active", mon, 3'h1);
		wr(asi_pkg::REG_CTRL, 32'h0000_0000);
		settle(3);
		check("role_standby", mon, 3'h2);
		wr(asi_pkg::REG_CTRL, 32'h0000_0006);
		toggles(0, n);
		check("role_db_blink", n >= 4, 1);
		toggles(2, n);
		check("fail_db_blink", n >= 4, 1);
		wr(asi_pkg::REG_CTRL, 32'h0000_0002);
		settle(3);
		toggles(0, n);
		check("role_no_blink", n, 0);
		for (int i = 0; i < 5; i++) begin
			wr(asi_pkg::REG_ALARM, 32'h0000_0001 << i);
			settle(2);
			check("alarm_lamps", alm_lamps, 5'h01 << i);
		end
		wr(asi_pkg::REG_ALARM, 0);
		wr(asi_pkg::REG_MASK, 32'h0000_0001);
		rd(asi_pkg::REG_IRQ, d);
		check("irq_sync_lost", d[4], 1);
		wr(asi_pkg::REG_ALARM, 32'h0000_0004);
		settle(2);
		check("irq_set", irq, 1);
		rd(asi_pkg::REG_IRQ, d);
		check("irq_status", d, 32'h0000_0001);
		settle(1);
		check("irq_cleared", irq, 0);
		wr(asi_pkg::REG_MASK, 0);
		wr(asi_pkg::REG_ALARM, 32'h0000_0005);
		settle(2);
		check("irq_masked", irq, 0);
		wr(asi_pkg::REG_ALARM, 0);
		settle(2);
		press();
		check("cut_no_alarm", {alarm_cutoff_lamp, audible_alarm_drive}, 0);
		wr(asi_pkg::REG_ALARM, 32'h0000_0001);
		settle(2);
		check("audible_on", audible_alarm_drive, 1);
		press();
		check("cut_taken", {alarm_cutoff_lamp, audible_alarm_drive}, 2);
		rd(asi_pkg::REG_STATUS, d);
		check("st_cut", d & 32'h0000_00c0, 32'h0000_0040);
		wr(asi_pkg::REG_ALARM, 32'h0000_0003);
		settle(2);
		check("cut_cancel", {alarm_cutoff_lamp, audible_alarm_drive}, 1);
		press();
		check("cut_again", {alarm_cutoff_lamp, audible_alarm_drive}, 2);
		wr(asi_pkg::REG_ALARM, 0);
		settle(2);
		check("cut_idle", {alarm_cutoff_lamp, audible_alarm_drive}, 0);
		rd(asi_pkg::REG_IRQ, d);
		check("irq_cut", d, 32'h0000_0007);
		for (int i = 0; i < 9; i++) begin
			@(posedge core_clk);
			supply_a_level <= lv[i];
			supply_b_level <= lv[(i + 3) % 9];
			settle(2);
			check("supply_a", supply_a_lamp, lx[i]);
			check("supply_b", supply_b_lamp, lx[(i + 3) % 9]);
			rd(asi_pkg::REG_STATUS, d);
			check("st_sup", d[5:0], {lx[(i + 3) % 9], lx[i]});
		end
		@(posedge core_clk);
		supply_a_level <= 12'h800;
		supply_b_level <= 12'h800;
		wr(asi_pkg::REG_MASK, 32'h0000_0008);
		settle(2);
		rd(asi_pkg::REG_IRQ, d);
		check("sup_good_audible", audible_alarm_drive, 0);
		@(posedge core_clk);
		supply_b_level <= 12'h300;
		settle(3);
		check("sup_bad_audible", {irq, audible_alarm_drive}, 3);
		rd(asi_pkg::REG_IRQ, d);
		check("sup_irq", d[3], 1);
		@(posedge core_clk);
		supply_b_level <= 12'h800;
		wr(asi_pkg::REG_THR_LO, 32'h0000_0700);
		rd(asi_pkg::REG_THR_LO, d);
		check("thr_lo_wr", d, 32'h0000_0700);
		@(posedge core_clk);
		supply_a_level <= 12'h650;
		settle(2);
		check("thr_prog_band", supply_a_lamp, 3'h2);
		wr(asi_pkg::REG_THR_LO, 32'h0000_0b00);
		rd(asi_pkg::REG_STATUS, d);
		check("thr_order", d[8], 0);
		wr(asi_pkg::REG_THR_LO, 32'h0000_0600);
		rd(asi_pkg::REG_STATUS, d);
		check("thr_order_ok", d[8], 1);
		print_verdict();
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		#(50 * 5000);
		miscompares++;
		print_verdict();
	end
endmodule
